// [src/cafe_params.svh]
// Purpose: constants of the analog front end configuration register bank
// Assumes: 16-bit serial words, msb first, two null bits, 4-bit address, 10 data bits
// Notes: clock control register sits at address 9
`ifndef CAFE_PARAMS_SVH
`define CAFE_PARAMS_SVH
`define CAFE_ADDR_GAIN 4'h1
`define CAFE_ADDR_CONV1 4'h2
`define CAFE_ADDR_CONV2 4'h3
`define CAFE_ADDR_BLACK 4'h5
`define CAFE_ADDR_MODE 4'h6
`define CAFE_ADDR_DELAY 4'h8
`define CAFE_ADDR_CLOCK 4'h9
`define CAFE_RST_GAIN 10'h000
`define CAFE_RST_CONV 10'h000
`define CAFE_RST_BLACK 10'h000
`define CAFE_RST_MODE 10'h000
`define CAFE_RST_DELAY 10'h0e9
`define CAFE_RST_CLOCK 10'h039
`define CAFE_RST_CONV_DELAY 5'h07
`define CAFE_RST_STROBE_DELAY 5'h09
`define CAFE_RST_WIDTH 3'h5
`define CAFE_BIT_BLACK_EN 4
`define CAFE_BIT_MODE 1
`define CAFE_BIT_STROBE_MON 4
`define CAFE_BIT_CONV_MON 3
`define CAFE_BIT_LATCH 2
`define CAFE_GAIN_CCD_MAX 10'h2ff
`define CAFE_GAIN_VID_BASE 10'h100
`define CAFE_BLACK_BASE 6'h14
`define CAFE_DELAY_MAX 5'h1d
`define CAFE_WORD_BITS 5'h10
`define CAFE_WIDTH_BASE 3'h4
`endif

// [src/cafe_pkg.sv]
// Purpose: types of the configuration register bank
// Assumes: nothing
// Notes: none
package cafe_pkg;
	typedef enum logic {CAFE_MODE_CCD, CAFE_MODE_VIDEO} cafe_mode_t;
	typedef logic [9:0] cafe_word_t;
endpackage

// [src/cafe_serial_rx.sv]
// Purpose: three-wire serial word receiver
// Assumes: pins asynchronous to sys_clk_i, sampled on rising serial clock edges
// Notes: a write fires only when exactly 16 bits arrived before select rises
`timescale 1ns/1ps
`include "cafe_params.svh"
module cafe_serial_rx (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// serial pins
	input wire logic ser_clk_i,
	input wire logic ser_data_i,
	input wire logic ser_sel_n_i,
	// decoded write
	output logic wr_o,
	output logic [3:0] wr_addr_o,
	output logic [9:0] wr_data_o
);
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic clk_d_reg;
	logic sel_d_reg;
	logic [15:0] shift_reg;
	logic [4:0] cnt_reg;
	wire clk_rise = s2_reg[0] & ~clk_d_reg;
	wire sel_rise = s2_reg[2] & ~sel_d_reg;
	wire sel_act = ~s2_reg[2];
	wire word_done = sel_rise & (cnt_reg == `CAFE_WORD_BITS);
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_reg <= 3'h4;
			s2_reg <= 3'h4;
			clk_d_reg <= 1'b0;
			sel_d_reg <= 1'b1;
		end else begin
			s1_reg <= {ser_sel_n_i, ser_data_i, ser_clk_i};
			s2_reg <= s1_reg;
			clk_d_reg <= s2_reg[0];
			sel_d_reg <= s2_reg[2];
		end
	end
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_reg <= 16'h0000;
			cnt_reg <= 5'h00;
		end else if (!sel_act) begin
			cnt_reg <= 5'h00;
		end else if (clk_rise && cnt_reg != 5'h1f) begin
			shift_reg <= {shift_reg[14:0], s2_reg[1]};
			cnt_reg <= cnt_reg + 5'h01;
		end
	end
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_o <= 1'b0;
			wr_addr_o <= 4'h0;
			wr_data_o <= 10'h000;
		end else begin
			wr_o <= word_done;
			if (word_done) begin
				wr_addr_o <= shift_reg[13:10];
				wr_data_o <= shift_reg[9:0];
			end
		end
	end
	property p_word_len;
		@(posedge sys_clk_i) disable iff (!rst_n_i) wr_o |-> $past(cnt_reg) == `CAFE_WORD_BITS;
	endproperty
	a_word_len: assert property (p_word_len) else $error("write without 16 bits");
	c_word: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) wr_o);
endmodule

// [src/cafe_strobe_gen.sv]
// Purpose: per-channel delay and width evaluation in thirtieths and twentieths of T
// Assumes: nothing
// Notes: outputs are the programmed timing figures, analog timing is outside
`timescale 1ns/1ps
`include "cafe_params.svh"
module cafe_strobe_gen (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// settings
	input wire logic [9:0] delay_i,
	input wire logic [1:0] width_sel_i,
	// timing figures
	output logic [4:0] conv_delay_o,
	output logic [4:0] strobe_delay_o,
	output logic [2:0] strobe_width_o
);
	wire [2:0] width_num = `CAFE_WIDTH_BASE + {1'b0, width_sel_i};
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			conv_delay_o <= `CAFE_RST_CONV_DELAY;
			strobe_delay_o <= `CAFE_RST_STROBE_DELAY;
			strobe_width_o <= `CAFE_RST_WIDTH;
		end else begin
			conv_delay_o <= delay_i[9:5];
			strobe_delay_o <= delay_i[4:0];
			strobe_width_o <= width_num;
		end
	end
endmodule

// [src/cafe_config_regs.sv]
// Purpose: configuration register bank of a ccd/video analog front end
// Assumes: host writes over select, serial clock and data pins
// Notes: gain leaves as a count of 0.047 dB steps above 0 dB; black target in lsb
`timescale 1ns/1ps
`include "cafe_params.svh"
module cafe_config_regs (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// serial port
	input wire logic ser_clk_i,
	input wire logic ser_data_i,
	input wire logic ser_sel_n_i,
	// gain
	output logic [9:0] gain_step_o,
	output logic video_mode_o,
	// user converters
	output logic [7:0] user_converter_one_out_o,
	output logic [7:0] user_converter_two_out_o,
	// black level
	output logic [5:0] optical_black_target_o,
	// timing
	output logic [4:0] conversion_clock_delay_o,
	output logic [4:0] reference_strobe_delay_o,
	output logic [2:0] strobe_width_o,
	output logic strobe_monitor_en_o,
	output logic conv_clock_monitor_en_o,
	output logic output_latch_edge_o,
	output logic half_cycle_delay_o
);
	logic wr;
	logic [3:0] wr_addr;
	logic [9:0] wr_data;
	cafe_pkg::cafe_word_t gain_code_reg;
	cafe_pkg::cafe_word_t user_converter_one_code_reg;
	cafe_pkg::cafe_word_t user_converter_two_code_reg;
	cafe_pkg::cafe_word_t black_level_setup_reg;
	cafe_pkg::cafe_word_t input_mode_control_reg;
	cafe_pkg::cafe_word_t sample_delay_control_reg;
	cafe_pkg::cafe_word_t clocking_control_reg;
	cafe_pkg::cafe_mode_t mode;

	cafe_serial_rx u_rx (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.ser_clk_i(ser_clk_i),
		.ser_data_i(ser_data_i),
		.ser_sel_n_i(ser_sel_n_i),
		.wr_o(wr),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data)
	);

	// address decode; other addresses fall through untouched
	wire wr_gain = wr & (wr_addr == `CAFE_ADDR_GAIN);
	wire wr_conv1 = wr & (wr_addr == `CAFE_ADDR_CONV1);
	wire wr_conv2 = wr & (wr_addr == `CAFE_ADDR_CONV2);
	wire wr_black = wr & (wr_addr == `CAFE_ADDR_BLACK);
	wire wr_mode = wr & (wr_addr == `CAFE_ADDR_MODE);
	wire wr_delay = wr & (wr_addr == `CAFE_ADDR_DELAY);
	wire wr_clock = wr & (wr_addr == `CAFE_ADDR_CLOCK);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gain_code_reg <= `CAFE_RST_GAIN;
			user_converter_one_code_reg <= `CAFE_RST_CONV;
			user_converter_two_code_reg <= `CAFE_RST_CONV;
			black_level_setup_reg <= `CAFE_RST_BLACK;
			input_mode_control_reg <= `CAFE_RST_MODE;
			sample_delay_control_reg <= `CAFE_RST_DELAY;
			clocking_control_reg <= `CAFE_RST_CLOCK;
		end else begin
			if (wr_gain) gain_code_reg <= wr_data;
			if (wr_conv1) user_converter_one_code_reg <= wr_data;
			if (wr_conv2) user_converter_two_code_reg <= wr_data;
			if (wr_black) black_level_setup_reg <= wr_data;
			if (wr_mode) input_mode_control_reg <= wr_data;
			if (wr_delay) sample_delay_control_reg <= wr_data;
			if (wr_clock) clocking_control_reg <= wr_data;
		end
	end

	assign mode = input_mode_control_reg[`CAFE_BIT_MODE] ? cafe_pkg::CAFE_MODE_VIDEO : cafe_pkg::CAFE_MODE_CCD;

	// gain mapping in units of 0.047 dB above 0 dB
	wire [9:0] ccd_code = (gain_code_reg > `CAFE_GAIN_CCD_MAX) ? `CAFE_GAIN_CCD_MAX : gain_code_reg;
	wire [9:0] vid_lim = (gain_code_reg > `CAFE_GAIN_CCD_MAX) ? `CAFE_GAIN_CCD_MAX : gain_code_reg;
	// codes below 256 are forbidden in video mode; floor them at 0 dB
	wire [9:0] vid_code = (vid_lim < `CAFE_GAIN_VID_BASE) ? 10'h000 : vid_lim - `CAFE_GAIN_VID_BASE;
	wire [9:0] gain_step_next = (mode == cafe_pkg::CAFE_MODE_VIDEO) ? vid_code : ccd_code;

	wire black_en = black_level_setup_reg[`CAFE_BIT_BLACK_EN];
	wire [5:0] black_next = black_en ? `CAFE_BLACK_BASE + {2'h0, black_level_setup_reg[3:0]} : 6'h00;

	wire latch_fall = clocking_control_reg[`CAFE_BIT_LATCH];

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gain_step_o <= 10'h000;
			video_mode_o <= 1'b0;
			user_converter_one_out_o <= 8'h00;
			user_converter_two_out_o <= 8'h00;
			optical_black_target_o <= 6'h00;
			strobe_monitor_en_o <= 1'b0;
			conv_clock_monitor_en_o <= 1'b0;
			output_latch_edge_o <= 1'b0;
			half_cycle_delay_o <= 1'b0;
		end else begin
			gain_step_o <= gain_step_next;
			video_mode_o <= (mode == cafe_pkg::CAFE_MODE_VIDEO);
			user_converter_one_out_o <= user_converter_one_code_reg[7:0];
			user_converter_two_out_o <= user_converter_two_code_reg[7:0];
			optical_black_target_o <= black_next;
			strobe_monitor_en_o <= ~clocking_control_reg[`CAFE_BIT_STROBE_MON];
			conv_clock_monitor_en_o <= ~clocking_control_reg[`CAFE_BIT_CONV_MON];
			output_latch_edge_o <= latch_fall;
			half_cycle_delay_o <= latch_fall;
		end
	end

	cafe_strobe_gen u_strobe (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.delay_i(sample_delay_control_reg),
		.width_sel_i(clocking_control_reg[1:0]),
		.conv_delay_o(conversion_clock_delay_o),
		.strobe_delay_o(reference_strobe_delay_o),
		.strobe_width_o(strobe_width_o)
	);

	property p_ccd_sat;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(mode == cafe_pkg::CAFE_MODE_CCD && gain_code_reg > `CAFE_GAIN_CCD_MAX) |=> gain_step_o == `CAFE_GAIN_CCD_MAX;
	endproperty
	a_ccd_sat: assert property (p_ccd_sat) else $error("ccd gain not saturated");
	property p_ccd_lin;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(mode == cafe_pkg::CAFE_MODE_CCD && gain_code_reg <= `CAFE_GAIN_CCD_MAX) |=> gain_step_o == $past(gain_code_reg);
	endproperty
	a_ccd_lin: assert property (p_ccd_lin) else $error("ccd gain not linear");
	property p_vid;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(mode == cafe_pkg::CAFE_MODE_VIDEO && gain_code_reg >= `CAFE_GAIN_VID_BASE && gain_code_reg <= `CAFE_GAIN_CCD_MAX)
		|=> gain_step_o == $past(gain_code_reg) - `CAFE_GAIN_VID_BASE;
	endproperty
	a_vid: assert property (p_vid) else $error("video gain offset wrong");
	property p_black_off;
		@(posedge sys_clk_i) disable iff (!rst_n_i) !black_en |=> optical_black_target_o == 6'h00;
	endproperty
	a_black_off: assert property (p_black_off) else $error("black target not zero");
	property p_black_on;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		black_en |=> optical_black_target_o == `CAFE_BLACK_BASE + {2'h0, $past(black_level_setup_reg[3:0])};
	endproperty
	a_black_on: assert property (p_black_on) else $error("black target wrong");
	property p_conv;
		@(posedge sys_clk_i) disable iff (!rst_n_i) wr_conv1 |=> ##1 user_converter_one_out_o == $past(wr_data[7:0], 2);
	endproperty
	a_conv: assert property (p_conv) else $error("converter code wrong");
	property p_mon;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		##1 (strobe_monitor_en_o != $past(clocking_control_reg[`CAFE_BIT_STROBE_MON]))
		&& (conv_clock_monitor_en_o != $past(clocking_control_reg[`CAFE_BIT_CONV_MON]));
	endproperty
	a_mon: assert property (p_mon) else $error("monitor enable wrong");
	property p_width;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		##1 strobe_width_o == `CAFE_WIDTH_BASE + {1'b0, $past(clocking_control_reg[1:0])};
	endproperty
	a_width: assert property (p_width) else $error("strobe width wrong");
	property p_unmapped;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(wr && (wr_addr == 4'h0 || wr_addr == 4'h4 || wr_addr == 4'h7 || wr_addr > 4'h9)) |=> $stable(gain_code_reg)
		&& $stable(clocking_control_reg) && $stable(sample_delay_control_reg);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped write changed state");

	// each output follows its register one cycle later; the gain register takes its write one cycle later
	property p_mode;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		##1 video_mode_o == $past(input_mode_control_reg[`CAFE_BIT_MODE]);
	endproperty
	a_mode: assert property (p_mode) else $error("input mode wrong");
	property p_latch;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		##1 (output_latch_edge_o == $past(clocking_control_reg[`CAFE_BIT_LATCH]))
		&& (half_cycle_delay_o == output_latch_edge_o);
	endproperty
	a_latch: assert property (p_latch) else $error("latch edge wrong");
	property p_conv_two;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		wr_conv2 |=> ##1 user_converter_two_out_o == $past(wr_data[7:0], 2);
	endproperty
	a_conv_two: assert property (p_conv_two) else $error("second converter code wrong");
	property p_delay;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		##1 {conversion_clock_delay_o, reference_strobe_delay_o} == $past(sample_delay_control_reg);
	endproperty
	a_delay: assert property (p_delay) else $error("delay codes wrong");
	property p_gain_wr;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		wr_gain |=> gain_code_reg == $past(wr_data);
	endproperty
	a_gain_wr: assert property (p_gain_wr) else $error("gain write lost");
	c_video: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) video_mode_o);
	c_fall: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) output_latch_edge_o);
	c_black: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) optical_black_target_o == 6'h23);
endmodule

// [dv/cafe_host_model.sv]
// Purpose: host side of the three-wire serial port, sends register words
// Assumes: serial clock 80 ns period, stands low outside words
// Notes: data shows the inverse of its last bit once select is released
`timescale 1ns/1ps
module cafe_host_model (
	// system clock for alignment
	input wire logic sys_clk_i,
	// serial pins
	output logic ser_clk_o,
	output logic ser_data_o,
	output logic ser_sel_n_o
);
	initial begin
		ser_clk_o = 1'b0;
		ser_data_o = 1'b0;
		ser_sel_n_o = 1'b1;
	end
	// sends the top n bits of w, msb first; n other than 16 makes a refused word
	task automatic send(input logic [15:0] w, input int n);
		@(posedge sys_clk_i);
		#1;
		ser_sel_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			ser_data_o = w[15 - i];
			#40;
			ser_clk_o = 1'b1;
			#40;
			ser_clk_o = 1'b0;
		end
		#10;
		ser_sel_n_o = 1'b1;
		ser_data_o = ~ser_data_o;
		// select stays high well beyond the required spacing
		repeat (4) @(posedge sys_clk_i);
	endtask
endmodule

// [dv/testbench.sv]
// Purpose: self-checking bench of the configuration register bank
// Assumes: expected outputs follow from a mirror of the written registers
// Notes: the driver notes each expectation; a watcher compares after each write
`timescale 1ns/1ps
module testbench;
	typedef struct {
		logic [9:0] gain;
		logic vm;
		logic [7:0] c1;
		logic [7:0] c2;
		logic [5:0] blk;
		logic [4:0] cd;
		logic [4:0] sd;
		logic [2:0] w;
		logic [3:0] ck;
	} cafe_exp_t;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	wire logic ser_clk, ser_data, ser_sel_n;
	wire logic [9:0] gain_step;
	wire logic video_mode, strobe_mon_en, conv_mon_en, latch_edge, half_delay;
	wire logic [7:0] conv1, conv2;
	wire logic [5:0] black;
	wire logic [4:0] conv_delay, strobe_delay;
	wire logic [2:0] strobe_width;
	logic [9:0] g, c1, c2, b, m, d, k;
	logic [9:0] ccd_codes[5] = '{10'h000, 10'h001, 10'h2ff, 10'h300, 10'h3ff};
	logic [9:0] vid_codes[5] = '{10'h100, 10'h101, 10'h200, 10'h201, 10'h2ff};
	cafe_exp_t exp_q[$];
	event res_ev;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	always #5 sys_clk = ~sys_clk;
	cafe_host_model host_u (.sys_clk_i(sys_clk), .ser_clk_o(ser_clk), .ser_data_o(ser_data), .ser_sel_n_o(ser_sel_n));
	cafe_config_regs dut_u (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .ser_clk_i(ser_clk), .ser_data_i(ser_data),
		.ser_sel_n_i(ser_sel_n), .gain_step_o(gain_step), .video_mode_o(video_mode),
		.user_converter_one_out_o(conv1), .user_converter_two_out_o(conv2), .optical_black_target_o(black),
		.conversion_clock_delay_o(conv_delay), .reference_strobe_delay_o(strobe_delay),
		.strobe_width_o(strobe_width), .strobe_monitor_en_o(strobe_mon_en),
		.conv_clock_monitor_en_o(conv_mon_en), .output_latch_edge_o(latch_edge), .half_cycle_delay_o(half_delay));
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
		num_checks++;
		if (seen !== expv) begin
			$display("CHECK FAILED %s expected %h seen %h", name, expv, seen);
			fail_count++;
		end
	endtask
	function automatic cafe_exp_t exp_now();
		cafe_exp_t e;
		logic [9:0] gc;
		gc = (g > 10'h2ff) ? 10'h2ff : g;
		e.gain = m[1] ? ((gc < 10'h100) ? 10'h000 : gc - 10'h100) : gc;
		e.vm = m[1];
		e.c1 = c1[7:0];
		e.c2 = c2[7:0];
		e.blk = b[4] ? 6'h14 + {2'h0, b[3:0]} : 6'h00;
		e.cd = d[9:5];
		e.sd = d[4:0];
		e.w = 3'h4 + {1'b0, k[1:0]};
		e.ck = {~k[4], ~k[3], k[2], k[2]};
		return e;
	endfunction
	task automatic note();
		exp_q.push_back(exp_now());
		->res_ev;
	endtask
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		{g, c1, c2, b, m} = {5{10'h000}};
		d = 10'h0e9;
		k = 10'h039;
		note();
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [9:0] v, input int n = 16);
		host_u.send({2'b00, a, v}, n);
		if (n == 16) begin
			case (a)
				4'h1: g = v;
				4'h2: c1 = v;
				4'h3: c2 = v;
				4'h5: b = v;
				4'h6: m = v;
				4'h8: d = v;
				4'h9: k = v;
				default: ;
			endcase
		end
		repeat (8) @(posedge sys_clk);
		#1;
		note();
	endtask
	always begin
		cafe_exp_t e;
		@(res_ev);
		e = exp_q.pop_front();
		check("gain_step", gain_step, e.gain);
		check("video_mode", video_mode, e.vm);
		check("converter_one", conv1, e.c1);
		check("converter_two", conv2, e.c2);
		check("black_target", black, e.blk);
		check("delays", {conv_delay, strobe_delay}, {e.cd, e.sd});
		check("strobe_width", strobe_width, e.w);
		check("clock_bits", {strobe_mon_en, conv_mon_en, latch_edge, half_delay}, e.ck);
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		void'($urandom(32'hf3780a09));
		do_reset();
		$display("test reset done");
		foreach (ccd_codes[i])
			wr(4'h1, ccd_codes[i]);
		wr(4'h1, 10'($urandom_range(767)));
		$display("test ccd gain done");
		wr(4'h1, 10'h100);
		wr(4'h6, 10'h002);
		foreach (vid_codes[i])
			wr(4'h1, vid_codes[i]);
		wr(4'h6, 10'h3fc);
		$display("test video gain done");
		wr(4'h2, 10'h3ff);
		wr(4'h3, 10'h300 | 10'($urandom_range(255)));
		wr(4'h2, 10'($urandom_range(1023)));
		$display("test converters done");
		wr(4'h5, 10'h3ef);
		for (int v = 0; v < 16; v++)
			wr(4'h5, {5'h1f, 1'b1, 4'(v)});
		$display("test black level done");
		wr(4'h8, {5'h1d, 5'h1d});
		wr(4'h8, 10'h000);
		repeat (3) wr(4'h8, {5'($urandom_range(29)), 5'($urandom_range(29))});
		$display("test delays done");
		for (int v = 0; v < 32; v++)
			wr(4'h9, {5'h01, 5'(v)});
		$display("test clock control done");
		for (int a = 0; a < 16; a++)
			if (!(a inside {1, 2, 3, 5, 6, 8, 9}))
				wr(4'(a), 10'($urandom_range(1023)) & 10'h3fe);
		wr(4'h1, 10'h155, 15);
		wr(4'h2, 10'h0aa, 8);
		$display("test refused writes done");
		do_reset();
		$display("test second reset done");
		#1;
		summarize();
	end
endmodule
